// ---- verilog/rate_timing_pkg.sv ----
// Constants for the bit-rate timing unit
`default_nettype none
package rate_timing_pkg;

    // Reference divider widths and table size
    localparam int unsigned DIV_W = 13;
    localparam int unsigned RATE_COUNT = 16;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned CHAR_LEN_W = 2;

    // Reset values of the configuration
    localparam logic [SEL_W-1:0] RATE_SEL_RST = 4'h0;
    localparam logic [CHAR_LEN_W-1:0] CHAR_LEN_RST = 2'h0;

    // Bit clock multipliers
    localparam int unsigned ASYNC_MULT = 16;
    localparam int unsigned SYNC_MULT = 1;

    // Divisors of the reference clock, one per selectable rate
    localparam logic [DIV_W-1:0] DIV_50 = 13'h18C0;
    localparam logic [DIV_W-1:0] DIV_75 = 13'h1080;
    localparam logic [DIV_W-1:0] DIV_110 = 13'h0B40;
    localparam logic [DIV_W-1:0] DIV_134_5 = 13'h0933;
    localparam logic [DIV_W-1:0] DIV_150 = 13'h0840;
    localparam logic [DIV_W-1:0] DIV_300 = 13'h0420;
    localparam logic [DIV_W-1:0] DIV_600 = 13'h0210;
    localparam logic [DIV_W-1:0] DIV_1200 = 13'h0108;
    localparam logic [DIV_W-1:0] DIV_1800 = 13'h00B0;
    localparam logic [DIV_W-1:0] DIV_2000 = 13'h009E;
    localparam logic [DIV_W-1:0] DIV_2400 = 13'h0084;
    localparam logic [DIV_W-1:0] DIV_3600 = 13'h0058;
    localparam logic [DIV_W-1:0] DIV_4800 = 13'h0042;
    localparam logic [DIV_W-1:0] DIV_7200 = 13'h002C;
    localparam logic [DIV_W-1:0] DIV_9600 = 13'h0021;
    localparam logic [DIV_W-1:0] DIV_19200 = 13'h0010;

endpackage
`default_nettype wire

// ---- verilog/baud_rate_timing_unit.sv ----
// Bit-rate clock generation for the serial transmitter and receiver
`timescale 1ns/1ps
`default_nettype none

// Operation
// [R1] Divide reference clock by selected fixed divisor
// [R2] Asynchronous mode: bit clock is sixteen times
// [R3] Synchronous mode: one clock per serial bit
// [R4] Sixteen rates, shared by transmit and receive
// [R5] External bit clocks or internally divided reference
// [R6] Host settings steer timing and serial sections
// [R7] Count to divisor, reload, never drift
module baud_rate_timing_unit
    import rate_timing_pkg::*;
#(
    parameter int unsigned DIVIDER_WIDTH = DIV_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ref_clk_in,
    input wire logic ext_tx_bit_clock,
    input wire logic ext_rx_bit_clock,
    input wire logic cfg_write,
    input wire logic [SEL_W-1:0] cfg_rate_sel,
    input wire logic cfg_sync_mode,
    input wire logic cfg_internal_clk,
    input wire logic [CHAR_LEN_W-1:0] cfg_char_len,
    output logic tx_bit_clock,
    output logic rx_bit_clock,
    output logic bit_tick,
    output logic sync_mode,
    output logic [2:0] sample_mult_log2,
    output logic [CHAR_LEN_W-1:0] char_len
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (DIVIDER_WIDTH < DIV_W) begin : g_bad_width
        $error("Divider width too small for largest divisor");
    end
    if ((1 << SEL_W) != RATE_COUNT) begin : g_bad_table
        $error("Rate selector width does not cover the rate table");
    end

    // ------------------------------------------------------------
    // Divisor lookup
    // ------------------------------------------------------------
    // Maps a rate selection onto its reference-clock divisor
    function automatic logic [DIV_W-1:0] divisor_of(input logic [SEL_W-1:0] sel);
        logic [DIV_W-1:0] d;
        d = DIV_50;
        unique case (sel)
            4'h0: d = DIV_50;
            4'h1: d = DIV_75;
            4'h2: d = DIV_110;
            4'h3: d = DIV_134_5;
            4'h4: d = DIV_150;
            4'h5: d = DIV_300;
            4'h6: d = DIV_600;
            4'h7: d = DIV_1200;
            4'h8: d = DIV_1800;
            4'h9: d = DIV_2000;
            4'hA: d = DIV_2400;
            4'hB: d = DIV_3600;
            4'hC: d = DIV_4800;
            4'hD: d = DIV_7200;
            4'hE: d = DIV_9600;
            4'hF: d = DIV_19200;
        endcase
        return d;
    endfunction

    // ------------------------------------------------------------
    // Configuration state
    // ------------------------------------------------------------
    logic [SEL_W-1:0] rate_sel_r;
    logic [SEL_W-1:0] rate_sel_nxt;
    logic sync_mode_r;
    logic sync_mode_nxt;
    logic internal_r;
    logic internal_nxt;
    logic [CHAR_LEN_W-1:0] char_len_r;
    logic [CHAR_LEN_W-1:0] char_len_nxt;

    // Host control word latches all settings at once
    always_comb begin
        rate_sel_nxt = rate_sel_r;
        sync_mode_nxt = sync_mode_r;
        internal_nxt = internal_r;
        char_len_nxt = char_len_r;
        if (cfg_write) begin // see [R6]
            rate_sel_nxt = cfg_rate_sel;
            sync_mode_nxt = cfg_sync_mode;
            internal_nxt = cfg_internal_clk;
            char_len_nxt = cfg_char_len;
        end
    end

    // Master reset clears the configuration
    always_ff @(posedge clk) begin
        if (reset) begin
            rate_sel_r <= RATE_SEL_RST;
            sync_mode_r <= 1'b0;
            internal_r <= 1'b0;
            char_len_r <= CHAR_LEN_RST;
        end else begin
            rate_sel_r <= rate_sel_nxt;
            sync_mode_r <= sync_mode_nxt;
            internal_r <= internal_nxt;
            char_len_r <= char_len_nxt;
        end
    end

    // ------------------------------------------------------------
    // Reference clock edge detection
    // ------------------------------------------------------------
    logic ref_prev_r;
    logic ref_rise;

    // Previous reference level, idle low after reset
    always_ff @(posedge clk) begin
        if (reset) begin
            ref_prev_r <= 1'b0;
        end else begin
            ref_prev_r <= ref_clk_in;
        end
    end

    // One pulse per reference clock rising edge
    assign ref_rise = ref_clk_in & ~ref_prev_r;

    // ------------------------------------------------------------
    // Rate divider
    // ------------------------------------------------------------
    // Counter increment at the counter width
    localparam logic [DIVIDER_WIDTH-1:0] CNT_ONE = DIVIDER_WIDTH'(1'b1);

    logic [DIVIDER_WIDTH-1:0] div_cnt_r;
    logic [DIVIDER_WIDTH-1:0] div_cnt_nxt;
    logic div_clk_r;
    logic div_clk_nxt;
    logic [DIVIDER_WIDTH-1:0] divisor;
    logic [DIVIDER_WIDTH-1:0] half_div;

    // Table divisor widened to the counter width
    assign divisor = DIVIDER_WIDTH'(divisor_of(rate_sel_r)); // see [R1] [R4]
    assign half_div = divisor >> 1;

    // Counts reference edges, wraps exactly at the divisor
    always_comb begin
        div_cnt_nxt = div_cnt_r;
        div_clk_nxt = div_clk_r;
        if (cfg_write) begin
            div_cnt_nxt = '0;
            div_clk_nxt = 1'b0;
        end else if (ref_rise) begin
            if (div_cnt_r >= divisor - CNT_ONE) begin // see [R7]
                div_cnt_nxt = '0;
                div_clk_nxt = 1'b0;
            end else begin
                div_cnt_nxt = div_cnt_r + CNT_ONE;
                div_clk_nxt = (div_cnt_r + CNT_ONE) >= half_div; // see [R1]
            end
        end
    end

    // Divider count and divided clock registers
    always_ff @(posedge clk) begin
        if (reset) begin
            div_cnt_r <= '0;
            div_clk_r <= 1'b0;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            div_clk_r <= div_clk_nxt;
        end
    end

    // ------------------------------------------------------------
    // Clock source select and outputs
    // ------------------------------------------------------------
    logic tx_nxt;
    logic rx_nxt;
    logic tick_nxt;

    // Internal divider feeds both directions; else external pins
    always_comb begin
        if (internal_r) begin // see [R5]
            tx_nxt = div_clk_r; // see [R4]
            rx_nxt = div_clk_r;
        end else begin
            tx_nxt = ext_tx_bit_clock;
            rx_nxt = ext_rx_bit_clock;
        end
        tick_nxt = tx_nxt & ~tx_bit_clock;
    end

    // Bit clocks and tick leave through flip-flops
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_bit_clock <= 1'b0;
            rx_bit_clock <= 1'b0;
            bit_tick <= 1'b0;
        end else begin
            tx_bit_clock <= tx_nxt;
            rx_bit_clock <= rx_nxt;
            bit_tick <= tick_nxt;
        end
    end

    // ------------------------------------------------------------
    // Settings handed to the serial sections
    // ------------------------------------------------------------
    // Sampling multiplier as a shift count: 16X async, 1X sync
    localparam logic [2:0] ASYNC_SHIFT = 3'($clog2(ASYNC_MULT));
    localparam logic [2:0] SYNC_SHIFT = 3'($clog2(SYNC_MULT));

    // Registered settings drive the serial sections directly
    assign sync_mode = sync_mode_r; // see [R6]
    assign sample_mult_log2 = sync_mode_r ? SYNC_SHIFT : ASYNC_SHIFT; // see [R2] [R3]
    assign char_len = char_len_r;

endmodule

`default_nettype wire

// ---- tb/line_partner.sv ----
// Reference and external bit clock sources
`timescale 1ns/1ps
`default_nettype none
module line_partner (
    input wire logic clk,
    output logic ref_clk_in,
    output logic ext_tx_bit_clock,
    output logic ext_rx_bit_clock
);
    int n = 0;
    // Free reference, offset external clocks
    initial begin
        ref_clk_in = 1'b0;
        ext_tx_bit_clock = 1'b0;
        ext_rx_bit_clock = 1'b0;
        forever begin
            @(negedge clk);
            n++;
            ref_clk_in = ~ref_clk_in;
            if (n % 20 == 0) ext_tx_bit_clock = ~ext_tx_bit_clock;
            if (n % 20 == 10) ext_rx_bit_clock = ~ext_rx_bit_clock;
        end
    end
endmodule
`default_nettype wire

// ---- tb/rate_timing_checker.sv ----
// Port assertions for the bit-rate timing unit
`timescale 1ns/1ps
`default_nettype none
module rate_timing_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic ext_tx_bit_clock,
    input wire logic ext_rx_bit_clock,
    input wire logic cfg_write,
    input wire logic cfg_sync_mode,
    input wire logic cfg_internal_clk,
    input wire logic [1:0] cfg_char_len,
    input wire logic tx_bit_clock,
    input wire logic rx_bit_clock,
    input wire logic bit_tick,
    input wire logic sync_mode,
    input wire logic [1:0] char_len,
    input wire logic [2:0] sample_mult_log2
);
    logic int_r;
    logic [1:0] age_r;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Tracks clock source and cycles since the last setting
    always_ff @(posedge clk) begin
        if (reset || cfg_write) age_r <= 2'h0;
        else if (age_r != 2'h3) age_r <= age_r + 2'h1;
        if (reset) int_r <= 1'b0;
        else if (cfg_write) int_r <= cfg_internal_clk;
    end
    property p_rst; disable iff (1'b0)
        reset |=> !sync_mode && char_len == 2'h0 && !tx_bit_clock && !bit_tick;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_sync; cfg_write |=> sync_mode == $past(cfg_sync_mode); endproperty
    a_sync: assert property (p_sync) else $error("mode not taken");
    property p_len; cfg_write |=> char_len == $past(cfg_char_len); endproperty
    a_len: assert property (p_len) else $error("length not taken");
    property p_hold; !cfg_write |=> $stable(sync_mode) && $stable(char_len); endproperty
    a_hold: assert property (p_hold) else $error("setting drifted");
    property p_tick; $rose(tx_bit_clock) |-> bit_tick; endproperty
    a_tick: assert property (p_tick) else $error("tick missing");
    property p_src; bit_tick |-> tx_bit_clock && !$past(tx_bit_clock); endproperty
    a_src: assert property (p_src) else $error("tick without rise");
    property p_gap; bit_tick |=> !bit_tick [*8]; endproperty
    a_gap: assert property (p_gap) else $error("ticks too close");
    property p_dup; int_r && age_r == 2'h3 |-> tx_bit_clock == rx_bit_clock; endproperty
    a_dup: assert property (p_dup) else $error("clocks differ");
    property p_ext; !int_r && age_r == 2'h3 && $stable(ext_tx_bit_clock) &&
        $past(ext_tx_bit_clock) == $past(ext_tx_bit_clock, 2) |-> tx_bit_clock == ext_tx_bit_clock;
    endproperty
    a_ext: assert property (p_ext) else $error("external clock lost");
    property p_mult; sample_mult_log2 == (sync_mode ? 3'h0 : 3'h4); endproperty
    a_mult: assert property (p_mult) else $error("multiplier wrong");
endmodule
bind baud_rate_timing_unit rate_timing_checker rate_timing_checker_i (.clk(clk), .reset(reset),
    .ext_tx_bit_clock(ext_tx_bit_clock), .ext_rx_bit_clock(ext_rx_bit_clock),
    .cfg_write(cfg_write), .cfg_sync_mode(cfg_sync_mode), .cfg_internal_clk(cfg_internal_clk),
    .cfg_char_len(cfg_char_len), .tx_bit_clock(tx_bit_clock), .rx_bit_clock(rx_bit_clock),
    .bit_tick(bit_tick), .sync_mode(sync_mode), .char_len(char_len),
    .sample_mult_log2(sample_mult_log2));
`default_nettype wire

// ---- tb/baud_rate_timing_unit_bench.sv ----
// Self-checking bench for the bit-rate timing unit
`timescale 1ns/1ps
`default_nettype none
module baud_rate_timing_unit_bench
    import rate_timing_pkg::*;
;
    logic clk = 0, reset = 1, ref_clk_in, ext_tx_bit_clock, ext_rx_bit_clock, cfg_write = 0;
    logic cfg_sync_mode = 0, cfg_internal_clk = 0, tx_bit_clock, rx_bit_clock, bit_tick, sync_mode;
    logic [SEL_W-1:0] cfg_rate_sel = 4'h0;
    logic [CHAR_LEN_W-1:0] cfg_char_len = 2'h0, char_len;
    logic [2:0] sample_mult_log2;
    int fails = 0, check_count = 0;
    initial forever #10 clk = ~clk;
    line_partner line_partner_i (.clk(clk), .ref_clk_in(ref_clk_in),
        .ext_tx_bit_clock(ext_tx_bit_clock), .ext_rx_bit_clock(ext_rx_bit_clock));
    baud_rate_timing_unit baud_rate_timing_unit_i (.clk(clk), .reset(reset),
        .ref_clk_in(ref_clk_in),
        .ext_tx_bit_clock(ext_tx_bit_clock), .ext_rx_bit_clock(ext_rx_bit_clock),
        .cfg_write(cfg_write), .cfg_rate_sel(cfg_rate_sel), .cfg_sync_mode(cfg_sync_mode),
        .cfg_internal_clk(cfg_internal_clk), .cfg_char_len(cfg_char_len),
        .tx_bit_clock(tx_bit_clock), .rx_bit_clock(rx_bit_clock), .bit_tick(bit_tick),
        .sync_mode(sync_mode), .sample_mult_log2(sample_mult_log2), .char_len(char_len));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic cfg(input logic [3:0] sel, input logic sm, input logic ic,
        input logic [1:0] len);
        @(negedge clk);
        cfg_rate_sel = sel;
        cfg_sync_mode = sm;
        cfg_internal_clk = ic;
        cfg_char_len = len;
        cfg_write = 1'b1;
        @(negedge clk);
        cfg_write = 1'b0;
    endtask
    // External clocks pass through in both directions
    task automatic test_ext;
        cfg(4'h0, 1'b0, 1'b0, 2'h3);
        check(char_len, 16'h0003);
        repeat (4) begin
            @(ext_tx_bit_clock);
            repeat (5) @(negedge clk);
            check(tx_bit_clock, ext_tx_bit_clock);
            check(rx_bit_clock, ext_rx_bit_clock);
        end
        $display("test_ext done");
    endtask
    // Tick spacing is twice the divisor, ref rises every 2 cycles
    task automatic test_rates;
        logic [3:0] sel [4] = '{4'hF, 4'hB, 4'hA, 4'h3};
        logic [DIV_W-1:0] div [4] = '{DIV_19200, DIV_3600, DIV_2400, DIV_134_5};
        int n;
        for (int i = 0; i < 4; i++) begin
            cfg(sel[i], i[0], 1'b1, i[1:0]);
            check(sync_mode, i[0]);
            check(sample_mult_log2, i[0] ? 16'h0000 : 16'h0004);
            check(char_len, i[1:0]);
            while (bit_tick !== 1'b1) @(negedge clk);
            @(negedge clk);
            n = 1;
            while (bit_tick !== 1'b1) begin
                n++;
                @(negedge clk);
            end
            check(n, 2 * div[i]);
        end
        $display("test_rates done");
    endtask
    // Reset in mid-run clears settings and clocks
    task automatic test_reset;
        cfg(4'h5, 1'b1, 1'b1, 2'h2);
        reset = 1'b1;
        repeat (3) @(negedge clk);
        check({sync_mode, char_len, tx_bit_clock, rx_bit_clock, bit_tick}, 16'h0000);
        reset = 1'b0;
        repeat (2) @(negedge clk);
        check(sample_mult_log2, 16'h0004);
        @(ext_tx_bit_clock);
        repeat (5) @(negedge clk);
        check(tx_bit_clock, ext_tx_bit_clock);
        $display("test_reset done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk);
        reset = 1'b0;
        test_ext;
        test_rates;
        test_reset;
        finish_test;
    end
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        finish_test;
    end
endmodule
`default_nettype wire
